// *** verilog/err_flag_defs.vh ***
// Constants of the controller error and status flag unit.
// Assumes a single 25 MHz clock; included by every design file.
`ifndef ERR_FLAG_DEFS_VH
`define ERR_FLAG_DEFS_VH

// Clock and watchdog time base
`define CLK_FREQ_MHZ     25
`define CLK_PERIOD_NS    40
`define WDOG_TICK_US     1000
`define WDOG_TICK_CYC    (`WDOG_TICK_US * `CLK_FREQ_MHZ)
`define WDOG_PRESET_RST  8'hc8

// Bus widths and responses
`define ADDR_W           14
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

// Special contact table, 32 contacts per word, contact n at bit n-1
`define A_CONTACT_LAST   14'h003c
`define CONTACT_WORD_HI  4'h1
`define CONTACT_WORD_PAR 4'h2

// Error code registers: printed index, byte address is four times it
`define ERRREG0_IDX      12'd4078
`define ERRREG1_IDX      12'd4079
`define ERRREG2_IDX      12'd4080
`define A_ERRREG0        {`ERRREG0_IDX, 2'b00}
`define A_ERRREG1        {`ERRREG1_IDX, 2'b00}
`define A_ERRREG2        {`ERRREG2_IDX, 2'b00}

// Control and status registers
`define A_CTRL           14'h0100
`define A_WDOG_PRESET    14'h0104
`define A_RETRY_LIM      14'h0108
`define A_IRQ_STAT       14'h010c
`define A_IRQ_MASK       14'h0110
`define A_RUN_STAT       14'h0114

// Control register bits (write one to act)
`define CTRL_START       0
`define CTRL_STOP        1
`define CTRL_NEW_CFG     2
`define CTRL_CLR_LATCH   3

// Flag vector positions, shared by interrupt status and mask
`define NFLAG            14
`define F_CRIT           0
`define F_NONCRIT        1
`define F_DIAG           2
`define F_BATT           3
`define F_MEM            4
`define F_IO             5
`define F_COMM           6
`define F_CFG            7
`define F_WDOG           8
`define F_PROG           9
`define F_MATH           10
`define F_SMART          11
`define F_PARITY         12
`define F_RACK           13

// Reset values
`define RETRY_LIM_RST    4'h3
`define IRQ_MASK_RST     14'h0000
`define ERR_CODE_W       16

`endif

// *** verilog/lite_slave.v ***
// AXI4-Lite slave front end: handshakes, write pulse, registered read data.
// Assumes the register decode answers rd_data_i and the hit flags combinationally.
`timescale 1ns/1ps
`default_nettype none
`include "err_flag_defs.vh"

module lite_slave (
   input  wire               clk_i,
   input  wire               rst_n_i,
   input  wire [`ADDR_W-1:0] awaddr_i,
   input  wire               awvalid_i,
   output reg                awready_o,
   input  wire [31:0]        wdata_i,
   input  wire [3:0]         wstrb_i,
   input  wire               wvalid_i,
   output reg                wready_o,
   output reg  [1:0]         bresp_o,
   output reg                bvalid_o,
   input  wire               bready_i,
   input  wire               arvalid_i,
   output reg                arready_o,
   output reg  [31:0]        rdata_o,
   output reg  [1:0]         rresp_o,
   output reg                rvalid_o,
   input  wire               rready_i,
   input  wire [31:0]        rd_data_i,
   input  wire               rd_hit_i,
   input  wire               wr_hit_i,
   output reg  [`ADDR_W-1:0] wr_addr_o,
   output reg  [31:0]        wr_data_o,
   output reg  [3:0]         wr_strb_o,
   output reg                wr_en_o
);

   reg aw_got_q;
   reg w_got_q;

   // Write channel: take address and data in either order, then respond
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         awready_o <= 1'b1;
         wready_o  <= 1'b1;
         bvalid_o  <= 1'b0;
         bresp_o   <= `RESP_OKAY;
         wr_en_o   <= 1'b0;
         wr_addr_o <= {`ADDR_W{1'b0}};
         wr_data_o <= 32'h0;
         wr_strb_o <= 4'h0;
      end else begin
         wr_en_o <= 1'b0;
         if (awvalid_i && awready_o) begin
            wr_addr_o <= awaddr_i;
            aw_got_q  <= 1'b1;
            awready_o <= 1'b0;
         end
         if (wvalid_i && wready_o) begin
            wr_data_o <= wdata_i;
            wr_strb_o <= wstrb_i;
            w_got_q   <= 1'b1;
            wready_o  <= 1'b0;
         end
         if (aw_got_q && w_got_q && !bvalid_o) begin
            wr_en_o  <= wr_hit_i;
            bvalid_o <= 1'b1;
            bresp_o  <= wr_hit_i ? `RESP_OKAY : `RESP_SLVERR;
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
         end
         if (bvalid_o && bready_i) begin
            bvalid_o  <= 1'b0;
            awready_o <= 1'b1;
            wready_o  <= 1'b1;
         end
      end
   end

   // Read channel: data sampled at the address handshake
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         arready_o <= 1'b1;
         rvalid_o  <= 1'b0;
         rdata_o   <= 32'h0;
         rresp_o   <= `RESP_OKAY;
      end else if (arvalid_i && arready_o) begin
         arready_o <= 1'b0;
         rvalid_o  <= 1'b1;
         rdata_o   <= rd_data_i;
         rresp_o   <= rd_hit_i ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_o && rready_i) begin
         rvalid_o  <= 1'b0;
         arready_o <= 1'b1;
      end
   end

endmodule // lite_slave

`default_nettype wire

// *** verilog/parity_retry.v ***
// I/O parity retry tracker with rack criticality capture.
// Assumes one check strobe per bus transfer attempt, error level alongside.
`timescale 1ns/1ps
`default_nettype none
`include "err_flag_defs.vh"

module parity_retry #(
   parameter LIM_W = 4
) (
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire             check_i,
   input  wire             err_i,
   input  wire             noncrit_i,
   input  wire [LIM_W-1:0] limit_i,
   output reg              par_o,
   output reg              rack_o
);

   reg [LIM_W-1:0] retry_q;

   // Count failed retries; flag only when the last allowed retry fails
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         retry_q <= {LIM_W{1'b0}};
         par_o   <= 1'b0;
         rack_o  <= 1'b0;
      end else if (check_i && err_i) begin
         if (retry_q == limit_i) begin
            par_o  <= 1'b1;
            rack_o <= noncrit_i;
         end else begin
            retry_q <= retry_q + 1'b1;
         end
      end else if (check_i) begin
         retry_q <= {LIM_W{1'b0}};
         par_o   <= 1'b0;
         rack_o  <= 1'b0;
      end
   end

endmodule // parity_retry

`default_nettype wire

// *** verilog/err_flag_unit.v ***
// Error and diagnostic status unit of a controller CPU: special contacts,
// error code registers, run control, scan watchdog and interrupt.
// Assumes event inputs are synchronous one-cycle pulses, levels where noted.
//
// Functional notes
// - Critical error sets flag, stops run
// - Non-critical error sets flag, run continues
// - Either battery low sets battery flag
// - Memory error flag latches until cleared
// - I/O bus error flag latches
// - Comm error set; next good transfer clears
// - Config differing from power-up sets flag
// - Scan watchdog expiry sets its flag
// - Program, math, smart-module flags separate
// - Parity flag only after all retries fail
// - Rack criticality reported with parity flag
// - Failure code written into three registers
// - All contacts readable as one table
`timescale 1ns/1ps
`default_nettype none
`include "err_flag_defs.vh"

module err_flag_unit #(
   parameter WDOG_TICK_CYC = `WDOG_TICK_CYC,
   parameter CFG_W         = 16,
   parameter LIM_W         = 4
) (
   input  wire                   REF_CLK_I,
   input  wire                   RST_B_I,
   // Error sources
   input  wire                   CRIT_ERR_I,
   input  wire                   NONCRIT_ERR_I,
   input  wire                   DIAG_ERR_I,
   input  wire                   CPU_BATT_LOW_I,
   input  wire                   MC_BATT_LOW_I,
   input  wire                   MEM_ERR_I,
   input  wire                   IO_BUS_ERR_I,
   input  wire                   COMM_ERR_I,
   input  wire                   COMM_OK_I,
   input  wire [CFG_W-1:0]       IO_CFG_I,
   input  wire                   SCAN_START_I,
   input  wire                   PROG_ERR_I,
   input  wire                   MATH_ERR_I,
   input  wire                   SMART_ERR_I,
   input  wire                   PAR_CHECK_I,
   input  wire                   PAR_ERR_I,
   input  wire                   PAR_RACK_NONCRIT_I,
   input  wire                   ERR_CODE_VALID_I,
   input  wire [`ERR_CODE_W-1:0] ERR_CODE_I,
   // Register bus
   input  wire [`ADDR_W-1:0]     S_AXI_AWADDR_I,
   input  wire                   S_AXI_AWVALID_I,
   output wire                   S_AXI_AWREADY_O,
   input  wire [31:0]            S_AXI_WDATA_I,
   input  wire [3:0]             S_AXI_WSTRB_I,
   input  wire                   S_AXI_WVALID_I,
   output wire                   S_AXI_WREADY_O,
   output wire [1:0]             S_AXI_BRESP_O,
   output wire                   S_AXI_BVALID_O,
   input  wire                   S_AXI_BREADY_I,
   input  wire [`ADDR_W-1:0]     S_AXI_ARADDR_I,
   input  wire                   S_AXI_ARVALID_I,
   output wire                   S_AXI_ARREADY_O,
   output wire [31:0]            S_AXI_RDATA_O,
   output wire [1:0]             S_AXI_RRESP_O,
   output wire                   S_AXI_RVALID_O,
   input  wire                   S_AXI_RREADY_I,
   // Status
   output reg                    RUN_O,
   output reg                    IRQ_O
);

   // Bus side strobes
   wire [`ADDR_W-1:0]     wr_addr;
   wire [31:0]            wr_data;
   wire [3:0]             wr_strb;
   wire                   wr_en;
   wire                   arready;
   wire                   rd_take;
   wire [31:0]            wmask;
   reg  [31:0]            rd_data;
   reg                    rd_hit;
   reg                    wr_hit;

   // Flag state
   reg                    crit_q;
   reg                    noncrit_q;
   reg                    diag_q;
   reg                    batt_q;
   reg                    mem_q;
   reg                    io_q;
   reg                    comm_q;
   reg                    cfg_q;
   reg                    wdog_q;
   reg                    prog_q;
   reg                    math_q;
   reg                    smart_q;
   wire                   par;
   wire                   rack;
   wire [`NFLAG-1:0]      flags;
   reg  [`NFLAG-1:0]      flags_prev_q;
   wire [`NFLAG-1:0]      flag_rise;

   // Software registers
   reg  [7:0]             wdog_preset_q;
   reg  [LIM_W-1:0]       retry_lim_q;
   reg  [`NFLAG-1:0]      irq_mask_q;
   reg  [`NFLAG-1:0]      irq_stat_q;
   reg  [`NFLAG-1:0]      irq_stat_d;

   // Configuration record
   reg                    booted_q;
   reg  [CFG_W-1:0]       cfg_rec_q;

   // Watchdog
   reg  [15:0]            tick_cnt_q;
   reg  [7:0]             wdog_cnt_q;
   wire                   tick;

   // Error code registers
   reg  [`ERR_CODE_W-1:0] err_code_q [0:2];

   // Control strobes decoded from a control register write
   wire ctrl_wr     = wr_en && (wr_addr == `A_CTRL) && wr_strb[0];
   wire sw_start    = ctrl_wr && wr_data[`CTRL_START];
   wire sw_stop     = ctrl_wr && wr_data[`CTRL_STOP];
   wire sw_new_cfg  = ctrl_wr && wr_data[`CTRL_NEW_CFG];
   wire sw_clr      = ctrl_wr && wr_data[`CTRL_CLR_LATCH];

   // Byte lane mask from write strobes
   assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                   {8{wr_strb[1]}}, {8{wr_strb[0]}}};

   // Read request taken this edge
   assign rd_take = S_AXI_ARVALID_I && arready;

   lite_slave u_slave (
      .clk_i     (REF_CLK_I),
      .rst_n_i   (RST_B_I),
      .awaddr_i  (S_AXI_AWADDR_I),
      .awvalid_i (S_AXI_AWVALID_I),
      .awready_o (S_AXI_AWREADY_O),
      .wdata_i   (S_AXI_WDATA_I),
      .wstrb_i   (S_AXI_WSTRB_I),
      .wvalid_i  (S_AXI_WVALID_I),
      .wready_o  (S_AXI_WREADY_O),
      .bresp_o   (S_AXI_BRESP_O),
      .bvalid_o  (S_AXI_BVALID_O),
      .bready_i  (S_AXI_BREADY_I),
      .arvalid_i (S_AXI_ARVALID_I),
      .arready_o (arready),
      .rdata_o   (S_AXI_RDATA_O),
      .rresp_o   (S_AXI_RRESP_O),
      .rvalid_o  (S_AXI_RVALID_O),
      .rready_i  (S_AXI_RREADY_I),
      .rd_data_i (rd_data),
      .rd_hit_i  (rd_hit),
      .wr_hit_i  (wr_hit),
      .wr_addr_o (wr_addr),
      .wr_data_o (wr_data),
      .wr_strb_o (wr_strb),
      .wr_en_o   (wr_en)
   );

   assign S_AXI_ARREADY_O = arready;

   // Run state: stop on critical error, which wins over a start
   always @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         RUN_O <= 1'b0;
      end else if (CRIT_ERR_I || sw_stop) begin
         RUN_O <= 1'b0;
      end else if (sw_start && !crit_q) begin
         RUN_O <= 1'b1;
      end
   end

   // Latched error flags; a new event wins over a software clear
   always @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         crit_q    <= 1'b0;
         noncrit_q <= 1'b0;
         diag_q    <= 1'b0;
         mem_q     <= 1'b0;
         io_q      <= 1'b0;
         wdog_q    <= 1'b0;
         prog_q    <= 1'b0;
         math_q    <= 1'b0;
         smart_q   <= 1'b0;
      end else begin
         crit_q    <= CRIT_ERR_I    | (crit_q    & ~sw_clr);
         noncrit_q <= NONCRIT_ERR_I | (noncrit_q & ~sw_clr);
         diag_q    <= DIAG_ERR_I    | (diag_q    & ~sw_clr);
         mem_q     <= MEM_ERR_I     | (mem_q     & ~sw_clr);
         io_q      <= IO_BUS_ERR_I  | (io_q      & ~sw_clr);
         wdog_q    <= (tick && wdog_cnt_q == wdog_preset_q && RUN_O) | (wdog_q & ~sw_clr);
         prog_q    <= PROG_ERR_I    | (prog_q    & ~sw_clr);
         math_q    <= MATH_ERR_I    | (math_q    & ~sw_clr);
         smart_q   <= SMART_ERR_I   | (smart_q   & ~sw_clr);
      end
   end

   // Battery flag follows either low-battery level
   always @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         batt_q <= 1'b0;
      end else begin
         batt_q <= CPU_BATT_LOW_I | MC_BATT_LOW_I;
      end
   end

   // Communications flag: set by error, cleared by next good transfer
   always @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         comm_q <= 1'b0;
      end else if (COMM_ERR_I) begin
         comm_q <= 1'b1;
      end else if (COMM_OK_I) begin
         comm_q <= 1'b0;
      end
   end

   // Configuration recorded after reset release and on each new-config command, compared otherwise
   always @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         booted_q  <= 1'b0;
         cfg_rec_q <= {CFG_W{1'b0}};
         cfg_q     <= 1'b0;
      end else if (!booted_q || sw_new_cfg) begin
         booted_q  <= 1'b1;
         cfg_rec_q <= IO_CFG_I;
         cfg_q     <= 1'b0;
      end else begin
         cfg_q <= (IO_CFG_I != cfg_rec_q) | cfg_q;
      end
   end

   // Millisecond tick for the scan watchdog
   assign tick = (tick_cnt_q == WDOG_TICK_CYC - 1);

   always @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         tick_cnt_q <= 16'h0;
      end else if (tick || SCAN_START_I) begin
         tick_cnt_q <= 16'h0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 16'h1;
      end
   end

   // Scan watchdog: restarted by each scan, counts ticks while running
   always @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         wdog_cnt_q <= 8'h0;
      end else if (SCAN_START_I || !RUN_O) begin
         wdog_cnt_q <= 8'h0;
      end else if (tick && wdog_cnt_q != wdog_preset_q) begin
         wdog_cnt_q <= wdog_cnt_q + 8'h1;
      end
   end

   parity_retry #(
      .LIM_W (LIM_W)
   ) u_parity (
      .clk_i     (REF_CLK_I),
      .rst_n_i   (RST_B_I),
      .check_i   (PAR_CHECK_I),
      .err_i     (PAR_ERR_I),
      .noncrit_i (PAR_RACK_NONCRIT_I),
      .limit_i   (retry_lim_q),
      .par_o     (par),
      .rack_o    (rack)
   );

   // Failure codes: newest in the first register, older ones shift on
   always @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         err_code_q[0] <= {`ERR_CODE_W{1'b0}};
         err_code_q[1] <= {`ERR_CODE_W{1'b0}};
         err_code_q[2] <= {`ERR_CODE_W{1'b0}};
      end else if (ERR_CODE_VALID_I) begin
         err_code_q[0] <= ERR_CODE_I;
         err_code_q[1] <= err_code_q[0];
         err_code_q[2] <= err_code_q[1];
      end
   end

   // Software-written configuration registers
   always @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         wdog_preset_q <= `WDOG_PRESET_RST;
         retry_lim_q   <= `RETRY_LIM_RST;
         irq_mask_q    <= `IRQ_MASK_RST;
      end else if (wr_en) begin
         if (wr_addr == `A_WDOG_PRESET && wr_strb[0])
            wdog_preset_q <= wr_data[7:0];
         if (wr_addr == `A_RETRY_LIM && wr_strb[0])
            retry_lim_q <= wr_data[LIM_W-1:0];
         if (wr_addr == `A_IRQ_MASK)
            irq_mask_q <= (irq_mask_q & ~wmask[`NFLAG-1:0]) | (wr_data[`NFLAG-1:0] & wmask[`NFLAG-1:0]);
      end
   end

   // Flag vector in interrupt layout
   assign flags = {rack, par, smart_q, math_q, prog_q, wdog_q, cfg_q,
                   comm_q, io_q, mem_q, batt_q, diag_q, noncrit_q, crit_q};
   assign flag_rise = flags & ~flags_prev_q;

   always @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         flags_prev_q <= {`NFLAG{1'b0}};
      end else begin
         flags_prev_q <= flags;
      end
   end

   // Sticky interrupt status per flag; reading clears, a new rise wins
   genvar gi;
   generate
      for (gi = 0; gi < `NFLAG; gi = gi + 1) begin : g_irq
         always @* begin
            irq_stat_d[gi] = flag_rise[gi] |
                             (irq_stat_q[gi] & ~(rd_take && S_AXI_ARADDR_I == `A_IRQ_STAT));
         end
      end
   endgenerate

   always @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         irq_stat_q <= {`NFLAG{1'b0}};
         IRQ_O      <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         IRQ_O      <= |(irq_stat_d & irq_mask_q);
      end
   end

   // Write decode for the response code
   always @* begin
      case (wr_addr)
         `A_CTRL, `A_WDOG_PRESET, `A_RETRY_LIM, `A_IRQ_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Read mux; the contact table spans the first sixteen words
   always @* begin
      rd_data = 32'h0;
      rd_hit  = 1'b1;
      if (S_AXI_ARADDR_I <= `A_CONTACT_LAST) begin
         if (S_AXI_ARADDR_I[5:2] == `CONTACT_WORD_HI)
            rd_data = {19'h0, smart_q, math_q, prog_q, wdog_q, 1'b0,
                       cfg_q, comm_q, io_q, mem_q, batt_q, diag_q,
                       noncrit_q, crit_q};
         else if (S_AXI_ARADDR_I[5:2] == `CONTACT_WORD_PAR)
            rd_data = {30'h0, rack, par};
      end else begin
         case (S_AXI_ARADDR_I)
            `A_ERRREG0:     rd_data = {16'h0, err_code_q[0]};
            `A_ERRREG1:     rd_data = {16'h0, err_code_q[1]};
            `A_ERRREG2:     rd_data = {16'h0, err_code_q[2]};
            `A_CTRL:        rd_data = 32'h0;
            `A_WDOG_PRESET: rd_data = {24'h0, wdog_preset_q};
            `A_RETRY_LIM:   rd_data = {{(32-LIM_W){1'b0}}, retry_lim_q};
            `A_IRQ_STAT:    rd_data = {18'h0, irq_stat_q};
            `A_IRQ_MASK:    rd_data = {18'h0, irq_mask_q};
            `A_RUN_STAT:    rd_data = {31'h0, RUN_O};
            default:        rd_hit  = 1'b0;
         endcase
      end
   end

endmodule // err_flag_unit

`default_nettype wire

// *** tb/err_flag_props.sv ***
// Port-level assertions for the error flag unit: run control, reset and bus.
// Assumes binding onto err_flag_unit with a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module err_flag_props (
   input wire        REF_CLK_I, RST_B_I, CRIT_ERR_I,
   input wire        S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I, S_AXI_WREADY_O,
   input wire [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O,
   input wire        S_AXI_BVALID_O, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_ARREADY_O,
   input wire [31:0] S_AXI_RDATA_O,
   input wire        S_AXI_RVALID_O, S_AXI_RREADY_I, RUN_O, IRQ_O
);
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_B_I);
   property p_crit_stop; CRIT_ERR_I |=> !RUN_O; endproperty
   a_crit_stop: assert property (p_crit_stop) else $error("run kept after critical error");
   property p_reset_clear; $rose(RST_B_I) |-> !RUN_O && !IRQ_O && !S_AXI_BVALID_O && !S_AXI_RVALID_O; endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
   property p_ar_answer; S_AXI_ARVALID_I && S_AXI_ARREADY_O |-> ##[1:2] S_AXI_RVALID_O; endproperty
   a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
   property p_ar_refuse; S_AXI_RVALID_O |-> !S_AXI_ARREADY_O; endproperty
   a_ar_refuse: assert property (p_ar_refuse) else $error("read accepted while busy");
   property p_aw_refuse; S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O; endproperty
   a_aw_refuse: assert property (p_aw_refuse) else $error("write accepted while busy");
   property p_r_hold; S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
   property p_b_hold; S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_b_after;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O |-> ##[1:2] S_AXI_BVALID_O;
   endproperty
   a_b_after: assert property (p_b_after) else $error("write not answered");
endmodule // err_flag_props
`default_nettype wire

// *** tb/controller_error_flag_unit_bench.sv ***
// Self-checking bench for the error flag unit over its AXI4-Lite registers.
// Assumes err_flag_unit and its constants header; short watchdog tick.
`timescale 1ns/1ps
`default_nettype none
`include "err_flag_defs.vh"
module controller_error_flag_unit_bench;
   reg clk = 0, rst_n = 0, cpu_b = 0, mc_b = 0, perr = 0, pnc = 0;
   reg awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   reg  [12:0] ev = 0;
   reg  [15:0] cfg = 16'h00a5, code = 0;
   reg  [13:0] aw = 0, ar = 0;
   reg  [31:0] wd = 0, d;
   reg  [1:0]  r;
   wire        awr, wrd, bv, arr, rv, run, irq;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   integer     n_errors = 0, num_checks = 0;
   err_flag_unit #(.WDOG_TICK_CYC(8)) err_flag_unit_i (.REF_CLK_I(clk), .RST_B_I(rst_n),
      .CRIT_ERR_I(ev[0]), .NONCRIT_ERR_I(ev[1]), .DIAG_ERR_I(ev[2]), .CPU_BATT_LOW_I(cpu_b), .MC_BATT_LOW_I(mc_b),
      .MEM_ERR_I(ev[3]), .IO_BUS_ERR_I(ev[4]), .COMM_ERR_I(ev[8]), .COMM_OK_I(ev[9]), .IO_CFG_I(cfg),
      .SCAN_START_I(ev[12]), .PROG_ERR_I(ev[5]), .MATH_ERR_I(ev[6]), .SMART_ERR_I(ev[7]), .PAR_CHECK_I(ev[10]),
      .PAR_ERR_I(perr), .PAR_RACK_NONCRIT_I(pnc), .ERR_CODE_VALID_I(ev[11]), .ERR_CODE_I(code),
      .S_AXI_AWADDR_I(aw), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
      .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(bresp),
      .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ar), .S_AXI_ARVALID_I(arv),
      .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
      .S_AXI_RREADY_I(rry), .RUN_O(run), .IRQ_O(irq));
   // Clock and hang guard
   always #20 clk = ~clk;
   initial begin
      #400000;
      n_errors = n_errors + 1;
      stop_test;
   end
   task chk(input [31:0] g, input [31:0] e);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
         end
      end
   endtask
   // Bus cycles: hold each channel until its ready edge, then idle one edge
   task wr(input [13:0] a, input [31:0] v);
      reg done;
      begin
         aw <= a; wd <= v; awv <= 1; wv <= 1; bry <= 1;
         done = 0;
         while (!done) begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
            if (bv) begin
               r = bresp;
               bry <= 0;
               done = 1;
            end
         end
         @(posedge clk);
      end
   endtask
   task rd(input [13:0] a);
      reg done;
      begin
         ar <= a; arv <= 1; rry <= 1;
         done = 0;
         while (!done) begin
            @(posedge clk);
            if (arr) arv <= 0;
            if (rv) begin
               d = rdata;
               r = rresp;
               rry <= 0;
               done = 1;
            end
         end
         @(posedge clk);
      end
   endtask
   task rdchk(input [13:0] a, input [31:0] e);
      begin
         rd(a);
         chk(d, e);
      end
   endtask
   task pulse(input [12:0] v);
      begin
         ev <= v;
         @(posedge clk);
         ev <= 0;
         @(posedge clk);
      end
   endtask
   task t_reset;
      begin
         rdchk(14'h0004, 32'h0);
         rdchk(14'h0008, 32'h0);
         rdchk(`A_ERRREG0, 32'h0);
      end
   endtask
   task t_run;
      begin
         wr(`A_CTRL, 1);
         chk(run, 1);
         pulse(13'h0002);
         chk(run, 1);
      end
   endtask
   task t_bits;
      begin
         pulse(13'h00fc);
         mc_b <= 1;
         pulse(0);
         rdchk(14'h0004, 32'h1c3e);
         mc_b <= 0; cpu_b <= 1;
         pulse(0);
         rdchk(14'h0004, 32'h1c3e);
         cpu_b <= 0;
         pulse(13'h0100);
         rdchk(14'h0004, 32'h1c76);
         pulse(13'h0200);
         rdchk(14'h0004, 32'h1c36);
         cfg <= 16'h005a;
         pulse(0);
         rdchk(14'h0004, 32'h1cb6);
         wr(`A_WDOG_PRESET, 1);
         pulse(13'h1000);
         rdchk(14'h0004, 32'h1cb6);
         repeat (40) @(posedge clk);
         rdchk(14'h0004, 32'h1eb6);
         pulse(13'h0001);
         chk(run, 0);
         rdchk(14'h0004, 32'h1eb7);
         rdchk(`A_RUN_STAT, 32'h0);
      end
   endtask
   task t_par;
      begin
         perr <= 1; pnc <= 1;
         repeat (3) pulse(13'h0400);
         rdchk(14'h0008, 32'h0);
         pulse(13'h0400);
         rdchk(14'h0008, 32'h3);
         perr <= 0;
         pulse(13'h0400);
         rdchk(14'h0008, 32'h0);
         perr <= 1; pnc <= 0;
         repeat (4) pulse(13'h0400);
         rdchk(14'h0008, 32'h1);
      end
   endtask
   task t_code;
      begin
         code <= 16'h0011; pulse(13'h0800);
         code <= 16'h0022; pulse(13'h0800);
         code <= 16'h0033; pulse(13'h0800);
         rdchk(`A_ERRREG0, 32'h33);
         rdchk(`A_ERRREG1, 32'h22);
         rdchk(`A_ERRREG2, 32'h11);
      end
   endtask
   task t_irq;
      begin
         wr(`A_IRQ_MASK, 32'h3fff);
         pulse(0);
         chk(irq, 1);
         rd(`A_IRQ_STAT);
         chk(d, 32'h3fff);
         pulse(0);
         chk(irq, 0);
         pulse(13'h0100);
         pulse(0);
         chk(irq, 1);
         wr(`A_IRQ_MASK, 0);
         pulse(0);
         chk(irq, 0);
      end
   endtask
   task t_bus;
      begin
         rd(14'h0200);
         chk(r, `RESP_SLVERR);
         chk(d, 32'h0);
         wr(14'h0004, 32'hffff);
         chk(r, `RESP_SLVERR);
         rdchk(14'h000c, 32'h0);
         rdchk(`A_CTRL, 32'h0);
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d errors %0d", num_checks, n_errors);
         if (n_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      t_reset; t_run; t_bits; t_par; t_code; t_irq; t_bus;
      stop_test;
   end
endmodule // controller_error_flag_unit_bench
bind err_flag_unit err_flag_props err_flag_props_i (.REF_CLK_I, .RST_B_I, .CRIT_ERR_I, .S_AXI_AWVALID_I,
   .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_RRESP_O, .S_AXI_BVALID_O,
   .S_AXI_BREADY_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I,
   .RUN_O, .IRQ_O);
`default_nettype wire
